// >>> rtl/macp_regs.vh
// register offsets, field positions and reset values of the user port block
`ifndef MACP_REGS_VH
`define MACP_REGS_VH

// ----------------------------------------------------------------
// register offsets (byte addresses, 10-bit space)
// ----------------------------------------------------------------
`define MACP_ADDR_W      10
`define MACP_OFS_IMR     10'h018
`define MACP_OFS_ISR     10'h01c

// ----------------------------------------------------------------
// interrupt cause bit positions (same in mask and status)
// ----------------------------------------------------------------
`define MACP_INT_RETRY_TMO  0
`define MACP_INT_RETRY_FAIL 1
`define MACP_INT_INBUF_OVF  2
`define MACP_INT_ERR_RESP   3
`define MACP_INT_N          4
`define MACP_IMR_RST        4'h0
`define MACP_ISR_RST        4'h0

// ----------------------------------------------------------------
// response sideband layout
// ----------------------------------------------------------------
`define MACP_ID_W        9
`define MACP_CMD_W       6
`define MACP_ERRST_W     7
`define MACP_LINK_W      3
`define MACP_USER_W      18
`define MACP_ADDR_HI     33
`define MACP_ALIGN_B     4
`define MACP_FLIT_W      128
`define MACP_ERR_W       10

`endif

// >>> rtl/macp_top.v
// user-side response channels, tag mapping and config port of the memory link bridge
//
// Local design decisions: the register addresses and the plain strobed port.
`include "macp_regs.vh"

module macp_top #(
    parameter RD_FLITS  = 2,              // read beat width in flits
    parameter MAX_FLITS = 8,              // largest read payload in flits
    parameter TAG_N     = 16,             // packet tags in the pool
    parameter TAG_W     = 4,              // tag index width
    parameter REORDER   = 1'b0,           // response reorder option built
    parameter [5:0] POSTED_CMD = 6'h00,   // command on internal responses
    parameter [2:0] LINK_ID    = 3'h0     // link id on internal responses
) (
    input  wire                   clk,            // system clock
    input  wire                   resetn,         // async system reset
    // write request notices from the write-address logic
    input  wire                   wreq_valid,     // write request taken
    input  wire [8:0]             wreq_id,        // its user id
    input  wire [TAG_W-1:0]       wreq_tag,       // its tag
    input  wire                   wreq_posted,    // posted write
    output wire                   wreq_ready,     // notice can be taken
    // write responses from the memory device
    input  wire                   dev_wresp_valid,  // device response
    input  wire [TAG_W-1:0]       dev_wresp_tag,    // its tag
    input  wire [17:0]            dev_wresp_user,   // its status fields
    output wire                   dev_wresp_ready,  // response taken
    // user write response channel
    output reg                    bvalid,         // response valid
    output reg  [8:0]             bid,            // response id
    output reg  [17:0]            write_resp_sideband, // status fields
    input  wire                   bready,         // user takes response
    // user read address channel
    input  wire                   arvalid,        // request valid
    input  wire [8:0]             arid,           // request id
    input  wire [8:0]             read_req_sideband, // cmd and device
    input  wire [33:0]            araddr,         // request address
    output wire                   arready,        // request taken
    // read requests toward the link
    output reg                    rreq_valid,     // request valid
    output reg  [TAG_W-1:0]       rreq_tag,       // packet tag
    output reg  [5:0]             rreq_cmd,       // read command
    output reg  [2:0]             rreq_target_device_id, // device id
    output reg  [33:0]            rreq_addr,      // aligned address
    input  wire                   rreq_ready,     // link takes request
    // read responses from the memory device
    input  wire                   dev_rresp_valid,  // device response
    input  wire [TAG_W-1:0]       dev_rresp_tag,    // its tag
    input  wire [17:0]            dev_rresp_user,   // its status fields
    input  wire [3:0]             dev_rresp_flits,  // payload flits
    input  wire [128*MAX_FLITS-1:0] dev_rresp_data, // payload
    output wire                   dev_rresp_ready,  // response taken
    // user read response channel
    output reg                    rvalid,         // beat valid
    output reg  [8:0]             rid,            // response id
    output reg  [17:0]            read_resp_sideband, // status fields
    output reg  [128*RD_FLITS-1:0] rdata,         // beat data
    output reg                    rlast,          // final beat
    input  wire                   rready,         // user takes beat
    // error response reports
    input  wire                   err_in_valid,   // report from link
    input  wire [9:0]             err_in_data,    // device and status
    output wire                   err_in_ready,   // report taken
    output reg                    errresp_valid,  // report valid
    output reg  [9:0]             errresp_data,   // device and status
    input  wire                   errresp_ready,  // user takes report
    // link events for interrupts
    input  wire                   retry_tmo_evt,  // retry time-out pulse
    input  wire                   retry_fail_evt, // retry failure pulse
    input  wire                   inbuf_ovf_evt,  // overflow pulse
    // register port
    input  wire                   csr_port_resetn, // port-only reset
    input  wire [9:0]             csr_addr,       // byte address
    input  wire [31:0]            csr_wdata,      // write data
    input  wire [3:0]             csr_wstrb,      // byte enables
    input  wire                   csr_wr,         // write strobe
    input  wire                   csr_rd,         // read strobe
    output reg  [31:0]            csr_rdata,      // read data
    output wire                   mem_int         // interrupt level
);

// ----------------------------------------------------------------
// constants and helpers
// ----------------------------------------------------------------
localparam RDW    = 128 * RD_FLITS;
localparam MAXW   = 128 * MAX_FLITS;
localparam UNPACK = (RD_FLITS != MAX_FLITS);

// lowest free tag; pool size is small so a priority scan is cheap
function [TAG_W-1:0] first_free;
    input [TAG_N-1:0] busy;
    integer k;
    begin
        first_free = {TAG_W{1'b0}};
        for (k = TAG_N - 1; k >= 0; k = k - 1) begin
            if (!busy[k])
                first_free = k[TAG_W-1:0];
        end
    end
endfunction

// beats for a payload; an empty payload still gives one beat
function [3:0] beats_of;
    input [3:0] flits;
    begin
        if (flits == 4'h0)
            beats_of = 4'h1;
        else
            beats_of = (flits + RD_FLITS[3:0] - 4'h1) / RD_FLITS[3:0];
    end
endfunction

// ----------------------------------------------------------------
// reset release
// ----------------------------------------------------------------
reg rst_s1;
reg rst_n;

// async assert, release after two edges
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        rst_s1 <= 1'b0;
        rst_n  <= 1'b0;
    end else begin
        rst_s1 <= 1'b1;
        rst_n  <= rst_s1;
    end
end

// ----------------------------------------------------------------
// write response channel
// ----------------------------------------------------------------
reg  [8:0] wid_tab [0:TAG_N-1];
wire       b_free = !bvalid || bready;

assign dev_wresp_ready = b_free;
assign wreq_ready      = !wreq_posted || (b_free && !dev_wresp_valid);

// remember ids of non-posted writes by tag
always @(posedge clk) begin
    if (wreq_valid && !wreq_posted)
        wid_tab[wreq_tag] <= wreq_id;
end

// one response slot, held until the user takes it
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        bvalid              <= 1'b0;
        bid                 <= 9'h000;
        write_resp_sideband <= 18'h00000;
    end else if (dev_wresp_valid && b_free) begin
        bvalid <= 1'b1;
        bid    <= wid_tab[dev_wresp_tag];
        write_resp_sideband <= {dev_wresp_user[17] & REORDER,
                                dev_wresp_user[16:0]};
    end else if (wreq_valid && wreq_posted && wreq_ready) begin
        bvalid              <= 1'b1;
        bid                 <= wreq_id;
        write_resp_sideband <= {1'b0, LINK_ID, 7'h00, 1'b0, POSTED_CMD};
    end else if (bready) begin
        bvalid <= 1'b0;
    end
end

// ----------------------------------------------------------------
// read address channel and tag pool
// ----------------------------------------------------------------
reg  [TAG_N-1:0] tag_busy;
reg  [8:0]       rid_tab [0:TAG_N-1];
reg  [TAG_W-1:0] r_tag;
wire [TAG_W-1:0] free_tag = first_free(tag_busy);
wire             any_free = ~&tag_busy;
wire             rq_free  = !rreq_valid || rreq_ready;
wire             ar_fire;
wire             r_done   = rvalid && rready && rlast;
integer          i;

// stall when no tag is free
assign arready = any_free && rq_free;
assign ar_fire = arvalid && arready;

// id of each outstanding read, by tag
always @(posedge clk) begin
    if (ar_fire)
        rid_tab[free_tag] <= arid;
end

// tag busy map; a tag frees on its last beat
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        tag_busy <= {TAG_N{1'b0}};
    end else begin
        for (i = 0; i < TAG_N; i = i + 1) begin
            if (ar_fire && free_tag == i)
                tag_busy[i] <= 1'b1;
            else if (r_done && r_tag == i)
                tag_busy[i] <= 1'b0;
        end
    end
end

// request toward the link, held until taken
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        rreq_valid            <= 1'b0;
        rreq_tag              <= {TAG_W{1'b0}};
        rreq_cmd              <= 6'h00;
        rreq_target_device_id <= 3'h0;
        rreq_addr             <= 34'h000000000;
    end else if (ar_fire) begin
        rreq_valid            <= 1'b1;
        rreq_tag              <= free_tag;
        rreq_cmd              <= read_req_sideband[5:0];
        rreq_target_device_id <= read_req_sideband[8:6];
        rreq_addr <= {araddr[`MACP_ADDR_HI:`MACP_ALIGN_B], 4'h0};
    end else if (rreq_ready) begin
        rreq_valid <= 1'b0;
    end
end

// ----------------------------------------------------------------
// read response channel
// ----------------------------------------------------------------
reg  [3:0] beats_left;
wire       rr_fire = dev_rresp_valid && dev_rresp_ready;
wire [3:0] nbeats  = beats_of(dev_rresp_flits);
wire [RDW-1:0] first_beat;
wire [RDW-1:0] next_beat;

// a new response waits for the last beat of the previous one
assign dev_rresp_ready = !rvalid;

// unpacking only when beat is narrower
generate
    if (UNPACK) begin : g_unpack
        reg [MAXW-1:0] pay_hold;
        assign first_beat = dev_rresp_data[RDW-1:0];
        assign next_beat  = pay_hold[RDW-1:0];
        // remaining payload shifts down one beat per handshake
        always @(posedge clk) begin
            if (rr_fire)
                pay_hold <= dev_rresp_data >> RDW;
            else if (rvalid && rready)
                pay_hold <= pay_hold >> RDW;
        end
    end else begin : g_whole
        assign first_beat = dev_rresp_data;
        assign next_beat  = {RDW{1'b0}};
    end
endgenerate

// beat sequencer
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        rvalid             <= 1'b0;
        rid                <= 9'h000;
        read_resp_sideband <= 18'h00000;
        rdata              <= {RDW{1'b0}};
        rlast              <= 1'b0;
        r_tag              <= {TAG_W{1'b0}};
        beats_left         <= 4'h0;
    end else if (rr_fire) begin
        rvalid <= 1'b1;
        r_tag  <= dev_rresp_tag;
        rid    <= rid_tab[dev_rresp_tag];
        read_resp_sideband <= {dev_rresp_user[17] & REORDER,
                               dev_rresp_user[16:0]};
        rdata      <= first_beat;
        beats_left <= nbeats - 4'h1;
        rlast      <= (nbeats == 4'h1);
    end else if (rvalid && rready) begin
        if (rlast) begin
            rvalid <= 1'b0;
            rlast  <= 1'b0;
        end else begin
            rdata      <= next_beat;
            beats_left <= beats_left - 4'h1;
            rlast      <= (beats_left == 4'h1);
        end
    end
end

// ----------------------------------------------------------------
// error response stream
// ----------------------------------------------------------------
wire err_load;

// single slot, refilled as it drains
assign err_in_ready = !errresp_valid || errresp_ready;
assign err_load     = err_in_valid && err_in_ready;

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        errresp_valid <= 1'b0;
        errresp_data  <= 10'h000;
    end else if (err_load) begin
        errresp_valid <= 1'b1;
        errresp_data  <= err_in_data;
    end else if (errresp_ready) begin
        errresp_valid <= 1'b0;
    end
end

// ----------------------------------------------------------------
// register port
// ----------------------------------------------------------------
reg  [3:0] int_mask;
reg  [3:0] int_stat;
wire [3:0] int_evt;
// byte lane 0 holds every defined bit
wire       wr_lane0 = csr_wr && csr_wstrb[0];
// address and data meet in one strobe cycle
wire       wr_imr   = wr_lane0 && csr_addr == `MACP_OFS_IMR;
wire       wr_isr   = wr_lane0 && csr_addr == `MACP_OFS_ISR;

assign int_evt[`MACP_INT_RETRY_TMO]  = retry_tmo_evt;
assign int_evt[`MACP_INT_RETRY_FAIL] = retry_fail_evt;
assign int_evt[`MACP_INT_INBUF_OVF]  = inbuf_ovf_evt;
assign int_evt[`MACP_INT_ERR_RESP]   = err_load;

// mask and sticky causes; an event beats its own clear
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        int_mask <= `MACP_IMR_RST;
        int_stat <= `MACP_ISR_RST;
    end else begin
        if (wr_imr)
            int_mask <= csr_wdata[3:0];
        if (wr_isr)
            int_stat <= (int_stat & ~csr_wdata[3:0]) | int_evt;
        else
            int_stat <= int_stat | int_evt;
    end
end

// level while an enabled cause stands
assign mem_int = |(int_stat & int_mask);

// read data valid one cycle after the strobe
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        csr_rdata <= 32'h00000000;
    end else if (!csr_port_resetn) begin
        csr_rdata <= 32'h00000000;
    end else if (csr_rd) begin
        case (csr_addr)
            `MACP_OFS_IMR: csr_rdata <= {28'h0000000, int_mask};
            `MACP_OFS_ISR: csr_rdata <= {28'h0000000, int_stat};
            default:       csr_rdata <= 32'h00000000;
        endcase
    end else begin
        csr_rdata <= 32'h00000000;
    end
end

endmodule

// >>> bench/macp_top_checker.sv
// concurrent checks on the user port of the memory link bridge
module macp_top_checker #(
    parameter RD_FLITS = 2  // beat width in flits
) (
    input logic                    clk,           // system clock
    input logic                    resetn,        // async reset
    input logic                    bvalid,        // response valid
    input logic [8:0]              bid,           // response id
    input logic                    bready,        // response taken
    input logic                    arvalid,       // request valid
    input logic [33:0]             araddr,        // request address
    input logic                    arready,       // request taken
    input logic                    rreq_valid,    // link request
    input logic [33:0]             rreq_addr,     // link address
    input logic                    rvalid,        // beat valid
    input logic [128*RD_FLITS-1:0] rdata,         // beat data
    input logic                    rlast,         // final beat
    input logic                    rready,        // beat taken
    input logic                    err_in_valid,  // report in
    input logic [9:0]              err_in_data,   // report data in
    input logic                    err_in_ready,  // report loaded
    input logic                    errresp_valid, // report out
    input logic [9:0]              errresp_data,  // report data out
    input logic                    errresp_ready, // report taken
    input logic                    csr_rd,        // read strobe
    input logic [31:0]             csr_rdata      // read data
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_bresp_holds: assert property (bvalid && !bready |=> bvalid && $stable(bid))
        else $error("write response dropped before ready");
    a_beat_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read beat changed before ready");
    a_err_holds: assert property (errresp_valid && !errresp_ready |=> $stable(errresp_data))
        else $error("error report changed before ready");
    a_err_loads: assert property (err_in_valid && err_in_ready |=>
        errresp_valid && errresp_data == $past(err_in_data))
        else $error("error report not passed on");
    a_req_issued: assert property (arvalid && arready |=>
        rreq_valid && rreq_addr == ($past(araddr) & ~34'hf))
        else $error("read request not issued aligned");
    a_last_ends: assert property (rvalid && rready && rlast |=> !rvalid)
        else $error("beat after final beat");
    a_mid_continues: assert property (rvalid && rready && !rlast |=> rvalid)
        else $error("burst ended without final beat");
    a_rdata_once: assert property (!csr_rd |=> csr_rdata == 32'h0)
        else $error("read data outside answer cycle");

    c_beat_stall: cover property (rvalid && !rready ##1 rvalid && rready && rlast);
    c_tags_full: cover property (!arready);
    c_err_stall: cover property (errresp_valid && !errresp_ready);
endmodule

bind macp_top macp_top_checker #(.RD_FLITS(RD_FLITS)) u_checker (.clk, .resetn, .bvalid, .bid,
    .bready, .arvalid, .araddr, .arready, .rreq_valid, .rreq_addr, .rvalid, .rdata, .rlast,
    .rready, .err_in_valid, .err_in_data, .err_in_ready, .errresp_valid, .errresp_data,
    .errresp_ready, .csr_rd, .csr_rdata);

// >>> bench/macp_user_model.sv
// user-side master model: takes responses, promptly or with random stalls
module macp_user_model (
    input  logic clk,           // system clock
    input  logic slow,          // stall often when high
    output logic bready,        // takes write responses
    output logic rready,        // takes read beats
    output logic errresp_ready  // takes error reports
);
    timeunit 1ns;
    timeprecision 1ns;
    integer     seed = 32'h76216418;
    logic [2:0] r;
    initial {bready, rready, errresp_ready} = 3'h0;
    // readiness per cycle
    // changes right after an edge, so a transfer is judged on settled levels
    always @(posedge clk) begin
        r = 3'($random(seed));
        bready        <= !slow || r[0];
        rready        <= !slow || r[1];
        errresp_ready <= !slow || r[2];
    end
endmodule

// >>> bench/test_macp_top.sv
// self-checking bench for the memory link user port
`include "macp_regs.vh"
module test_macp_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int RD = 2;
    localparam int LIMIT = 5000;
    logic clk = 1'h0, resetn = 1'h0, slow = 1'h0, csr_port_resetn = 1'h1;
    logic wreq_valid = 1'h0, wreq_posted = 1'h0, dev_wresp_valid = 1'h0, arvalid = 1'h0;
    logic dev_rresp_valid = 1'h0, err_in_valid = 1'h0, csr_wr = 1'h0, csr_rd = 1'h0;
    logic retry_tmo_evt = 1'h0, retry_fail_evt = 1'h0, inbuf_ovf_evt = 1'h0;
    logic [8:0] wreq_id = 9'h0, arid = 9'h0, read_req_sideband = 9'h0, bid, rid, s;
    logic [3:0] wreq_tag = 4'h0, dev_wresp_tag = 4'h0, dev_rresp_tag = 4'h0, rreq_tag;
    logic [3:0] dev_rresp_flits = 4'h0, csr_wstrb = 4'h0;
    logic [17:0] dev_wresp_user = 18'h0, dev_rresp_user = 18'h0, u;
    logic [17:0] write_resp_sideband, read_resp_sideband;
    logic [33:0] araddr = 34'h0, rreq_addr;
    logic [63:0] a;
    logic [1023:0] dev_rresp_data = 1024'h0, d;
    logic [255:0] rdata;
    logic [9:0] err_in_data = 10'h0, csr_addr = 10'h0, errresp_data, e;
    logic [31:0] csr_wdata = 32'h0, csr_rdata;
    logic [5:0] rreq_cmd;
    logic [2:0] rreq_target_device_id;
    logic wreq_ready, dev_wresp_ready, bvalid, bready, arready, rreq_valid, dev_rresp_ready;
    logic rvalid, rlast, rready, err_in_ready, errresp_valid, errresp_ready, mem_int;
    integer seed = 32'h76216418, n_mismatch = 0, checks_done = 0, cycles = 0, i, j, k, f;

    macp_top #(.RD_FLITS(RD)) dut (.clk, .resetn, .wreq_valid, .wreq_id, .wreq_tag, .wreq_posted,
        .wreq_ready, .dev_wresp_valid, .dev_wresp_tag, .dev_wresp_user, .dev_wresp_ready, .bvalid,
        .bid, .write_resp_sideband, .bready, .arvalid, .arid, .read_req_sideband, .araddr, .arready,
        .rreq_valid, .rreq_tag, .rreq_cmd, .rreq_target_device_id, .rreq_addr, .rreq_ready(1'h1),
        .dev_rresp_valid, .dev_rresp_tag, .dev_rresp_user, .dev_rresp_flits, .dev_rresp_data,
        .dev_rresp_ready, .rvalid, .rid, .read_resp_sideband, .rdata, .rlast, .rready,
        .err_in_valid, .err_in_data, .err_in_ready, .errresp_valid, .errresp_data, .errresp_ready,
        .retry_tmo_evt, .retry_fail_evt, .inbuf_ovf_evt, .csr_port_resetn, .csr_addr, .csr_wdata,
        .csr_wstrb, .csr_wr, .csr_rd, .csr_rdata, .mem_int);
    macp_user_model u_user (.clk, .slow, .bready, .rready, .errresp_ready);

    // 50 MHz system clock
    always #10 clk = ~clk;

    task automatic chk(input logic [255:0] got, input logic [255:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude;
        if (n_mismatch == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // beats per response: an empty payload still needs one beat to carry the status
    function automatic int n_beats(input int fl);
        return (fl == 0) ? 1 : (fl + RD - 1) / RD;
    endfunction

    task automatic csr_write(input logic [9:0] ad, input logic [31:0] wd, input logic [3:0] st);
        @(posedge clk);
        {csr_wr, csr_addr, csr_wdata, csr_wstrb} <= {1'h1, ad, wd, st};
        @(posedge clk);
        csr_wr <= 1'h0;
    endtask

    // data is valid only in the cycle after the strobe, so sample mid-cycle there
    task automatic csr_read(input logic [9:0] ad);
        @(posedge clk);
        {csr_rd, csr_addr} <= {1'h1, ad};
        @(posedge clk);
        csr_rd <= 1'h0;
        @(negedge clk);
    endtask

    task automatic wresp_case(input logic posted);
        u = 18'($random(seed));
        s = 9'($random(seed));
        @(posedge clk);
        {wreq_valid, wreq_id, wreq_tag, wreq_posted} <= {1'h1, s, s[3:0], posted};
        do @(posedge clk); while (!wreq_ready);
        wreq_valid <= 1'h0;
        if (!posted) begin
            {dev_wresp_valid, dev_wresp_tag, dev_wresp_user} <= {1'h1, s[3:0], u};
            do @(posedge clk); while (!dev_wresp_ready);
            dev_wresp_valid <= 1'h0;
        end
        do @(negedge clk); while (!(bvalid && bready));
        chk(bid, s);
        chk(write_resp_sideband, posted ? 18'h0 : {1'h0, u[16:0]});
    endtask

    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1'h1;
        repeat (3) @(posedge clk);
        // no init sequence lives here, so mask and status come first
        csr_read(`MACP_OFS_IMR);
        chk(csr_rdata, 32'h0);
        csr_read(`MACP_OFS_ISR);
        chk(csr_rdata, 32'h0);
        csr_write(`MACP_OFS_IMR, 32'hffffffff, 4'hf);
        csr_read(`MACP_OFS_IMR);
        chk(csr_rdata, 32'hf);
        for (i = 0; i < 20; i++) begin
            slow <= i[2];
            wresp_case(i[0]);
        end
        slow <= 1'h1;
        for (i = 0; i < 4; i++) begin
            e = 10'($random(seed));
            @(posedge clk);
            {err_in_valid, err_in_data} <= {1'h1, e};
            do @(posedge clk); while (!err_in_ready);
            err_in_valid <= 1'h0;
            do @(negedge clk); while (!(errresp_valid && errresp_ready));
            chk(errresp_data, e);
        end
        @(posedge clk);
        {retry_tmo_evt, retry_fail_evt, inbuf_ovf_evt} <= 3'h7;
        @(posedge clk);
        {retry_tmo_evt, retry_fail_evt, inbuf_ovf_evt} <= 3'h0;
        csr_read(`MACP_OFS_ISR);
        chk(csr_rdata, 32'hf);
        chk(mem_int, 1'h1);
        csr_write(`MACP_OFS_ISR, 32'hf, 4'he);
        csr_write(`MACP_OFS_ISR, 32'h2, 4'h1);
        csr_read(`MACP_OFS_ISR);
        chk(csr_rdata, 32'hd);
        @(posedge clk);
        csr_port_resetn <= 1'h0;
        @(posedge clk);
        csr_port_resetn <= 1'h1;
        csr_write(10'h3fc, 32'hffffffff, 4'hf);
        csr_read(10'h3fc);
        chk(csr_rdata, 32'h0);
        csr_read(`MACP_OFS_IMR);
        chk(csr_rdata, 32'hf);
        csr_write(`MACP_OFS_IMR, 32'h0, 4'hf);
        csr_read(`MACP_OFS_ISR);
        chk(mem_int, 1'h0);
        // sequential ids until every tag is taken
        for (i = 0; i < 16; i++) begin
            a = {$random(seed), $random(seed)};
            s = 9'($random(seed));
            @(posedge clk);
            // ids run in sequence from 0x40
            {arvalid, arid, read_req_sideband, araddr} <= {1'h1, 9'(9'h40 + i), s, a[33:0]};
            do @(posedge clk); while (!arready);
            arvalid <= 1'h0;
            do @(negedge clk); while (!rreq_valid);
            chk(rreq_addr, {a[33:4], 4'h0});
            chk({rreq_target_device_id, rreq_cmd}, s);
            chk(rreq_tag, i[3:0]);
        end
        chk(arready, 1'h0);
        // answer in reverse order, payload size j mod 9 flits, covering empty to largest
        for (j = 15; j >= 0; j--) begin
            f = j % 9;
            for (k = 0; k < 32; k++) d[k*32 +: 32] = $random(seed);
            u = 18'($random(seed));
            @(posedge clk);
            {dev_rresp_valid, dev_rresp_tag, dev_rresp_flits} <= {1'h1, j[3:0], f[3:0]};
            {dev_rresp_user, dev_rresp_data} <= {u, d};
            do @(posedge clk); while (!dev_rresp_ready);
            dev_rresp_valid <= 1'h0;
            for (k = 0; k < n_beats(f); k++) begin
                do @(negedge clk); while (!(rvalid && rready));
                chk(rdata, d[k*256 +: 256]);
                chk(rlast, k == n_beats(f) - 1);
                chk(rid, 9'(9'h40 + j));
                chk(read_resp_sideband, {1'h0, u[16:0]});
            end
        end
        conclude;
    end

    // watchdog: a hang counts as a mismatch and closes the run
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == LIMIT) begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value at %0t: run did not finish", $time);
            conclude;
        end
    end
endmodule
